// ===== verilog/fws_poller.sv
// Purpose: Host-side controller that polls flash program/erase status
// Assumes: Avalon-MM slave for software, flash pins synchronous
// Notes:   Software sends unlock cycles itself with write operations
`include "fws_map.svh"
`timescale 1ns/1ns
`default_nettype none

module fws_poller (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic [7:0]  i_fl_dq_in,
    output logic [7:0]       o_fl_dq_out,
    output logic             o_fl_dq_oe,
    output logic             o_fl_ce_n,
    output logic             o_fl_oe_n,
    output logic             o_fl_we_n,
    output logic [16:0]      o_fl_addr
);

    fws_pkg::fws_state_e st_q, st_d;
    logic [16:0] addr_q, addr_d;
    logic [7:0]  wdat_q, wdat_d, cwd_q, cwd_d;
    logic [7:0]  b1_q, b1_d, b2_q, b2_d, last_q, last_d;
    logic        skip_q, skip_d, iss_q, iss_d, cs_q, cs_d, cwe_q, cwe_d;
    logic        ok_q, ok_d, fail_q, fail_d, tog_q, tog_d, sec_q, sec_d;
    logic        late_q, late_d, lost_q, lost_d, ab_q, ab_d;
    logic        wait_d;
    logic [31:0] rdat_d, regrd, wmask;
    logic        acc, wr_fire, cmd_wr, is_wr, flips;
    logic [2:0]  op;
    logic        cyc_done;
    logic [7:0]  cyc_rdata;

    // Byte lanes of a write
    always_comb
    begin
        wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                 {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    end

    // Register read view; unmapped offsets read zero
    always_comb
    begin
        regrd = 32'h00000000;
        case (i_avs_address)
            `FWS_OFF_ADDR:  regrd = {15'h0000, addr_q};
            `FWS_OFF_WDATA: regrd = {24'h000000, wdat_q};
            `FWS_OFF_CTRL:  regrd = {31'h00000000, skip_q};
            `FWS_OFF_STAT:
            begin
                regrd[`FWS_ST_BUSY] = (st_q != fws_pkg::ST_IDLE);
                regrd[`FWS_ST_OK] = ok_q;
                regrd[`FWS_ST_FAIL] = fail_q;
                regrd[`FWS_ST_TOG] = tog_q;
                regrd[`FWS_ST_SEC] = sec_q;
                regrd[`FWS_ST_LATE] = late_q;
                regrd[`FWS_ST_LOST] = lost_q;
                regrd[`FWS_ST_BYTE +: 8] = last_q;
            end
            default: regrd = 32'h00000000;
        endcase
    end

    // Bus slave: answer one cycle after the request is seen
    always_comb
    begin
        acc = (i_avs_read || i_avs_write) && o_avs_waitrequest;
        wait_d = !acc;
        rdat_d = (acc && i_avs_read) ? regrd : o_avs_readdata;
        wr_fire = i_avs_write && !o_avs_waitrequest;
        cmd_wr = wr_fire && (i_avs_address == `FWS_OFF_CMD)
                 && i_avs_byteenable[0];
        op = i_avs_writedata[2:0];
    end

    // Sequencer next state
    always_comb
    begin
        st_d = st_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        skip_d = skip_q;
        cwd_d = cwd_q;
        cwe_d = cwe_q;
        cs_d = 1'b0;
        iss_d = iss_q;
        b1_d = b1_q;
        b2_d = b2_q;
        last_d = last_q;
        ok_d = ok_q;
        fail_d = fail_q;
        tog_d = tog_q;
        sec_d = sec_q;
        late_d = late_q;
        lost_d = lost_q;
        ab_d = ab_q;
        flips = b1_q[`FWS_TOGGLE_STATUS_BIT] ^ b2_q[`FWS_TOGGLE_STATUS_BIT];
        is_wr = (st_q == fws_pkg::ST_RST) || (st_q == fws_pkg::ST_GW)
                || (st_q == fws_pkg::ST_SW);
        // Plain register writes, byte lane masked
        if (wr_fire && i_avs_address == `FWS_OFF_ADDR)
            addr_d = 17'((({15'h0000, addr_q} & ~wmask)
                          | (i_avs_writedata & wmask)));
        if (wr_fire && i_avs_address == `FWS_OFF_WDATA
            && i_avs_byteenable[0])
            wdat_d = i_avs_writedata[7:0];
        if (wr_fire && i_avs_address == `FWS_OFF_CTRL
            && i_avs_byteenable[0])
            skip_d = i_avs_writedata[0];
        // Abort is held until the sequencer is back in idle
        if (cmd_wr && i_avs_writedata[`FWS_CMD_ABORT]
            && st_q != fws_pkg::ST_IDLE)
            ab_d = 1'b1;
        // Issue one pin cycle on entry to each cycle state
        if (st_q != fws_pkg::ST_IDLE && st_q != fws_pkg::ST_PCHK
            && st_q != fws_pkg::ST_PCHK2 && !iss_q)
        begin
            cs_d = 1'b1;
            iss_d = 1'b1;
            cwe_d = is_wr;
            cwd_d = (st_q == fws_pkg::ST_RST) ? `FWS_RESET_DATA : wdat_q;
        end
        if (iss_q && cyc_done)
        begin
            iss_d = 1'b0;
            if (!is_wr)
                last_d = cyc_rdata;
        end
        case (st_q)
            fws_pkg::ST_IDLE:
            begin
                ab_d = 1'b0;
                if (cmd_wr && !i_avs_writedata[`FWS_CMD_ABORT])
                begin
                    ok_d = 1'b0;
                    fail_d = 1'b0;
                    late_d = 1'b0;
                    lost_d = 1'b0;
                    case (op)
                        `FWS_OP_READ:  st_d = fws_pkg::ST_SR;
                        `FWS_OP_WRITE: st_d = fws_pkg::ST_SW;
                        `FWS_OP_POLL:  st_d = fws_pkg::ST_PR1;
                        `FWS_OP_RESET: st_d = fws_pkg::ST_RST;
                        // Fast hosts may leave out both window checks
                        `FWS_OP_GUARD: st_d = skip_q ? fws_pkg::ST_GW
                                                     : fws_pkg::ST_GR1;
                        default:       st_d = fws_pkg::ST_IDLE;
                    endcase
                end
            end
            // Two back-to-back reads at the address register
            fws_pkg::ST_PR1, fws_pkg::ST_PR3:
                if (iss_q && cyc_done)
                begin
                    b1_d = cyc_rdata;
                    st_d = ab_q ? fws_pkg::ST_IDLE
                         : (st_q == fws_pkg::ST_PR1) ? fws_pkg::ST_PR2
                                                     : fws_pkg::ST_PR4;
                end
            fws_pkg::ST_PR2, fws_pkg::ST_PR4:
                if (iss_q && cyc_done)
                begin
                    b2_d = cyc_rdata;
                    st_d = ab_q ? fws_pkg::ST_IDLE
                         : (st_q == fws_pkg::ST_PR2) ? fws_pkg::ST_PCHK
                                                     : fws_pkg::ST_PCHK2;
                end
            // First compare; timeout flag forces one recheck
            fws_pkg::ST_PCHK:
            begin
                tog_d = flips;
                sec_d = b1_q[`FWS_SECTOR_TOGGLE_BIT]
                        ^ b2_q[`FWS_SECTOR_TOGGLE_BIT];
                if (ab_q)
                    st_d = fws_pkg::ST_IDLE;
                else if (!flips)
                begin
                    ok_d = 1'b1;
                    st_d = fws_pkg::ST_IDLE;
                end
                else if (b2_q[`FWS_TIMEOUT_FAIL_FLAG])
                    st_d = fws_pkg::ST_PR3;
                else
                    st_d = fws_pkg::ST_PR1;
            end
            // Recheck: still toggling means failure and reset
            fws_pkg::ST_PCHK2:
            begin
                tog_d = flips;
                if (!flips)
                begin
                    ok_d = 1'b1;
                    st_d = fws_pkg::ST_IDLE;
                end
                else
                begin
                    fail_d = 1'b1;
                    st_d = fws_pkg::ST_RST;
                end
            end
            fws_pkg::ST_RST, fws_pkg::ST_SR, fws_pkg::ST_SW:
                if (iss_q && cyc_done)
                begin
                    ok_d = !fail_q;
                    st_d = fws_pkg::ST_IDLE;
                end
            // Window must still be open before the added command
            fws_pkg::ST_GR1:
                if (iss_q && cyc_done)
                begin
                    if (cyc_rdata[`FWS_ERASE_WINDOW_FLAG] || ab_q)
                    begin
                        late_d = !ab_q;
                        st_d = fws_pkg::ST_IDLE;
                    end
                    else
                        st_d = fws_pkg::ST_GW;
                end
            fws_pkg::ST_GW:
                if (iss_q && cyc_done)
                begin
                    ok_d = skip_q;
                    st_d = (skip_q || ab_q) ? fws_pkg::ST_IDLE
                                            : fws_pkg::ST_GR2;
                end
            // Closed window afterwards: the command may be lost
            fws_pkg::ST_GR2:
                if (iss_q && cyc_done)
                begin
                    lost_d = cyc_rdata[`FWS_ERASE_WINDOW_FLAG];
                    ok_d = !cyc_rdata[`FWS_ERASE_WINDOW_FLAG];
                    st_d = fws_pkg::ST_IDLE;
                end
            default:
                st_d = fws_pkg::ST_IDLE;
        endcase
    end

    // State and register storage
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st_q <= fws_pkg::ST_IDLE;
            addr_q <= 17'h00000;
            wdat_q <= 8'h00;
            skip_q <= 1'b0;
            cwd_q <= 8'h00;
            cwe_q <= 1'b0;
            cs_q <= 1'b0;
            iss_q <= 1'b0;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            last_q <= 8'h00;
            ok_q <= 1'b0;
            fail_q <= 1'b0;
            tog_q <= 1'b0;
            sec_q <= 1'b0;
            late_q <= 1'b0;
            lost_q <= 1'b0;
            ab_q <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h00000000;
        end
        else
        begin
            st_q <= st_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            skip_q <= skip_d;
            cwd_q <= cwd_d;
            cwe_q <= cwe_d;
            cs_q <= cs_d;
            iss_q <= iss_d;
            b1_q <= b1_d;
            b2_q <= b2_d;
            last_q <= last_d;
            ok_q <= ok_d;
            fail_q <= fail_d;
            tog_q <= tog_d;
            sec_q <= sec_d;
            late_q <= late_d;
            lost_q <= lost_d;
            ab_q <= ab_d;
            o_avs_waitrequest <= wait_d;
            o_avs_readdata <= rdat_d;
        end
    end

    // Pin cycle engine; every read goes to the address register
    fws_cyc u_cyc (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_start  (cs_q),
        .i_we     (cwe_q),
        .i_addr   (addr_q),
        .i_wdata  (cwd_q),
        .i_dq_in  (i_fl_dq_in),
        .o_done   (cyc_done),
        .o_rdata  (cyc_rdata),
        .o_ce_n   (o_fl_ce_n),
        .o_oe_n   (o_fl_oe_n),
        .o_we_n   (o_fl_we_n),
        .o_addr   (o_fl_addr),
        .o_dq_out (o_fl_dq_out),
        .o_dq_oe  (o_fl_dq_oe)
    );

    wait_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("waitrequest answer wrong");
    two_reads_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == fws_pkg::ST_PCHK |-> $past(st_q) == fws_pkg::ST_PR2)
        else $error("compare without two reads");
    recheck_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == fws_pkg::ST_PCHK && flips && !ab_q
        && b2_q[`FWS_TIMEOUT_FAIL_FLAG] |=> st_q == fws_pkg::ST_PR3)
        else $error("no recheck on timeout flag");
    fail_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == fws_pkg::ST_PCHK2 && flips
        |=> st_q == fws_pkg::ST_RST && fail_q ##1 cs_q)
        else $error("failure without reset command");
    reset_data_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cs_q && st_q == fws_pkg::ST_RST |-> cwe_q && cwd_q == `FWS_RESET_DATA)
        else $error("reset command data wrong");
    restart_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == fws_pkg::ST_IDLE && cmd_wr && op == `FWS_OP_POLL
        && !i_avs_writedata[`FWS_CMD_ABORT] |=> st_q == fws_pkg::ST_PR1)
        else $error("poll not started at top");
    pair_bits_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == fws_pkg::ST_PCHK |=> sec_q == $past(b1_q[2] ^ b2_q[2])
        && tog_q == $past(flips))
        else $error("toggle pair result wrong");
    window_late_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == fws_pkg::ST_GR1 && iss_q && cyc_done && !ab_q
        && cyc_rdata[3] |=> late_q && st_q == fws_pkg::ST_IDLE)
        else $error("closed window not refused");
    skip_check_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == fws_pkg::ST_IDLE && cmd_wr && op == `FWS_OP_GUARD && skip_q
        && !i_avs_writedata[7] |=> st_q == fws_pkg::ST_GW)
        else $error("window check not skipped");

endmodule

`default_nettype wire

// ===== include/fws_map.svh
// Purpose: Offsets, field positions and timing counts of the status poller
// Assumes: 125 MHz clock; byte offsets on the Avalon-MM slave
// Notes:   Definitions only
`ifndef FWS_MAP_SVH
`define FWS_MAP_SVH

// Register byte offsets
`define FWS_OFF_ADDR   5'h00
`define FWS_OFF_WDATA  5'h04
`define FWS_OFF_CTRL   5'h08
`define FWS_OFF_CMD    5'h0c
`define FWS_OFF_STAT   5'h10

// Operation codes written to the command register
`define FWS_OP_READ    3'h1
`define FWS_OP_WRITE   3'h2
`define FWS_OP_POLL    3'h3
`define FWS_OP_RESET   3'h4
`define FWS_OP_GUARD   3'h5
`define FWS_CMD_ABORT  7

// Status register fields
`define FWS_ST_BUSY    0
`define FWS_ST_OK      1
`define FWS_ST_FAIL    2
`define FWS_ST_TOG     3
`define FWS_ST_SEC     4
`define FWS_ST_LATE    5
`define FWS_ST_LOST    6
`define FWS_ST_BYTE    8

// Bit positions of the status byte on the flash data pins
`define FWS_TOGGLE_STATUS_BIT  6
`define FWS_TIMEOUT_FAIL_FLAG  5
`define FWS_ERASE_WINDOW_FLAG  3
`define FWS_SECTOR_TOGGLE_BIT  2

// Reset command data byte
`define FWS_RESET_DATA 8'hf0

// Pin cycle timing, least times rounded up to whole cycles
`define FWS_CLK_NS     8
`define FWS_SETUP_NS   10
`define FWS_PULSE_NS   90
`define FWS_REC_NS     30
`define FWS_SETUP_CYC  ((`FWS_SETUP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_PULSE_CYC  ((`FWS_PULSE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_REC_CYC    ((`FWS_REC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)

`endif

// ===== include/fws_pkg.sv
// Purpose: Types shared by the status poller files
// Assumes: Nothing
// Notes:   Constants live in fws_map.svh
package fws_pkg;

    // Main sequencer, Gray along the polling path
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_PR1   = 4'h1,
        ST_PR2   = 4'h3,
        ST_PCHK  = 4'h2,
        ST_PR3   = 4'h6,
        ST_PR4   = 4'h7,
        ST_PCHK2 = 4'h5,
        ST_RST   = 4'h4,
        ST_GR1   = 4'hc,
        ST_GW    = 4'hd,
        ST_GR2   = 4'hf,
        ST_SR    = 4'he,
        ST_SW    = 4'ha
    } fws_state_e;

    // Pin cycle phases
    typedef enum logic [1:0] {
        CY_IDLE  = 2'b00,
        CY_SETUP = 2'b01,
        CY_STRB  = 2'b11,
        CY_REC   = 2'b10
    } fws_cyc_e;

endpackage

// ===== verilog/fws_cyc.sv
// Purpose: One read or write cycle on the flash pins
// Assumes: Flash data input synchronous to i_clk
// Notes:   Start is ignored while a cycle is in flight
`include "fws_map.svh"
`timescale 1ns/1ns
`default_nettype none

module fws_cyc (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic        i_we,
    input  wire logic [16:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic [7:0]  i_dq_in,
    output logic             o_done,
    output logic [7:0]       o_rdata,
    output logic             o_ce_n,
    output logic             o_oe_n,
    output logic             o_we_n,
    output logic [16:0]      o_addr,
    output logic [7:0]       o_dq_out,
    output logic             o_dq_oe
);

    fws_pkg::fws_cyc_e ph_q, ph_d;
    logic [3:0]  cnt_q, cnt_d;
    logic        we_q, we_d, done_d, ce_n_d, oe_n_d, we_n_d, dq_oe_d;
    logic [16:0] addr_d;
    logic [7:0]  rd_d, wd_d;

    // Phase sequencing; data kept driven through recovery for hold time
    always_comb
    begin
        ph_d = ph_q;
        cnt_d = cnt_q;
        we_d = we_q;
        done_d = 1'b0;
        ce_n_d = o_ce_n;
        oe_n_d = o_oe_n;
        we_n_d = o_we_n;
        dq_oe_d = o_dq_oe;
        addr_d = o_addr;
        rd_d = o_rdata;
        wd_d = o_dq_out;
        case (ph_q)
            fws_pkg::CY_IDLE:
                if (i_start)
                begin
                    ph_d = fws_pkg::CY_SETUP;
                    cnt_d = 4'(`FWS_SETUP_CYC - 1);
                    we_d = i_we;
                    addr_d = i_addr;
                    wd_d = i_wdata;
                    ce_n_d = 1'b0;
                    dq_oe_d = i_we;
                end
            fws_pkg::CY_SETUP:
                if (cnt_q == 4'h0)
                begin
                    ph_d = fws_pkg::CY_STRB;
                    cnt_d = 4'(`FWS_PULSE_CYC - 1);
                    oe_n_d = we_q;
                    we_n_d = !we_q;
                end
                else
                    cnt_d = cnt_q - 4'h1;
            fws_pkg::CY_STRB:
                if (cnt_q == 4'h0)
                begin
                    ph_d = fws_pkg::CY_REC;
                    cnt_d = 4'(`FWS_REC_CYC - 1);
                    if (!we_q)
                        rd_d = i_dq_in;
                    oe_n_d = 1'b1;
                    we_n_d = 1'b1;
                    ce_n_d = 1'b1;
                end
                else
                    cnt_d = cnt_q - 4'h1;
            fws_pkg::CY_REC:
                if (cnt_q == 4'h0)
                begin
                    ph_d = fws_pkg::CY_IDLE;
                    dq_oe_d = 1'b0;
                    done_d = 1'b1;
                end
                else
                    cnt_d = cnt_q - 4'h1;
            default:
                ph_d = fws_pkg::CY_IDLE;
        endcase
    end

    // Register stage, enable and strobe pins idle high after reset
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ph_q <= fws_pkg::CY_IDLE;
            cnt_q <= 4'h0;
            we_q <= 1'b0;
            o_done <= 1'b0;
            o_rdata <= 8'h00;
            o_ce_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            o_addr <= 17'h00000;
            o_dq_out <= 8'h00;
            o_dq_oe <= 1'b0;
        end
        else
        begin
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            we_q <= we_d;
            o_done <= done_d;
            o_rdata <= rd_d;
            o_ce_n <= ce_n_d;
            o_oe_n <= oe_n_d;
            o_we_n <= we_n_d;
            o_addr <= addr_d;
            o_dq_out <= wd_d;
            o_dq_oe <= dq_oe_d;
        end
    end

    strobe_excl_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !(!o_oe_n && !o_we_n))
        else $error("both strobes low");
    addr_stable_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_ce_n && !$past(o_ce_n) |-> $stable(o_addr))
        else $error("address moved in cycle");
    cyc_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_start && ph_q == fws_pkg::CY_IDLE |-> ##[17:19] o_done)
        else $error("pin cycle length wrong");

endmodule

`default_nettype wire

// ===== dv/fws_flash_model.sv
// Purpose: Behavioural flash answering status reads
// Assumes: Pins sampled on i_clk
// Notes:   Released data pins show the inverted last value
`timescale 1ns/1ns
`default_nettype none
module fws_flash_model (
    input  wire logic       i_clk,
    input  wire logic       i_ce_n,
    input  wire logic       i_oe_n,
    input  wire logic       i_we_n,
    input  wire logic [7:0] i_dq,
    input  wire logic [7:0] i_busy_len,
    input  wire logic [7:0] i_array,
    input  wire logic       i_fail,
    input  wire logic       i_win,
    input  wire logic       i_susp,
    output logic [7:0]      o_dq,
    output logic [7:0]      o_resets
);
    logic       tog_q  = 1'b0;
    logic       oe_q   = 1'b1;
    logic       we_q   = 1'b1;
    logic [7:0] left_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic [7:0] rst_q  = 8'h00;
    logic       drv;
    // Status byte while busy, array data once done
    assign drv = !i_ce_n && !i_oe_n;
    // Suspended: status bit and polling bit stand high, sector bit toggles
    assign o_dq = !drv ? ~last_q : (left_q != 8'h00) ?
        {i_susp | ~i_array[7], i_susp | tog_q, i_fail, 1'b0, i_win,
         tog_q, 2'b00}
        : i_array;
    assign o_resets = rst_q;
    // Write strobe rise starts or ends work; read end advances toggle
    always @(posedge i_clk)
    begin
        oe_q <= i_oe_n;
        we_q <= i_we_n;
        if (drv)
            last_q <= o_dq;
        if (i_we_n && !we_q)
        begin
            rst_q  <= rst_q + {7'h00, i_dq == 8'hf0};
            left_q <= (i_dq == 8'hf0) ? 8'h00 : i_busy_len;
        end
        else if (i_oe_n && !oe_q && left_q != 8'h00)
        begin
            tog_q  <= ~tog_q;
            left_q <= left_q - {7'h00, !i_fail && !i_susp};
        end
    end
endmodule
`default_nettype wire

// ===== dv/fws_poller_test.sv
// Purpose: Self-checking bench for the status poller
// Assumes: Flash model on the pins
// Notes:   Status reads are judged by a scoreboard process
`include "fws_map.svh"
`timescale 1ns/1ns
`default_nettype none
module fws_poller_test;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [4:0]  adr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat, q, e, m, ex;
    logic        wrq, dq_oe, ce_n, oe_n, we_n;
    logic        fail = 1'b0;
    logic        win = 1'b0;
    logic        susp = 1'b0;
    logic [7:0]  blen = 8'h00;
    logic [7:0]  arr = 8'h00;
    logic [7:0]  dq_i, dq_o, rsts;
    logic [16:0] fl_a;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    integer      seed = 27;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    fws_poller dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wrq), .i_fl_dq_in(dq_i), .o_fl_dq_out(dq_o),
        .o_fl_dq_oe(dq_oe), .o_fl_ce_n(ce_n), .o_fl_oe_n(oe_n),
        .o_fl_we_n(we_n), .o_fl_addr(fl_a));
    fws_flash_model fl_u (.i_clk(i_clk), .i_ce_n(ce_n), .i_oe_n(oe_n),
        .i_we_n(we_n), .i_dq(dq_o), .i_busy_len(blen), .i_array(arr),
        .i_fail(fail), .i_win(win), .i_susp(susp), .o_dq(dq_i),
        .o_resets(rsts));
    // Free-running clock
    initial
    begin
        forever #4 i_clk = ~i_clk;
    end
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, g, x);
        end
    endtask
    // Holds the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wr  <= w;
        rd  <= !w;
        wd  <= d;
        @(posedge i_clk);
        while (wrq !== 1'b0)
        begin
            n++;
            if (n > 100)
                chk(32'h0, 32'h1);
            if (n > 100)
                finish_test;
            @(posedge i_clk);
        end
        // Accepting edge: take data, release, let one edge pass
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_clk);
    endtask
    // Bounded wait for busy to drop
    task automatic op(input logic [2:0] c);
        int k;
        k = 0;
        bus(1'b1, `FWS_OFF_CMD, {29'h0, c});
        q = 32'h1;
        while (q[`FWS_ST_BUSY] !== 1'b0 && k < 3000)
        begin
            k++;
            bus(1'b0, `FWS_OFF_STAT, 32'h0);
        end
        if (k >= 3000)
            chk(32'h0, 32'h1);
        if (k >= 3000)
            finish_test;
    endtask
    task automatic exp_rd(input logic [4:0] a, input logic [31:0] v,
                          input logic [31:0] mk);
        exp_q.push_back(v);
        msk_q.push_back(mk);
        bus(1'b0, a, 32'h0);
    endtask
    // Scoreboard takes the oldest note on each accepted read
    always @(posedge i_clk)
    begin
        if (rd === 1'b1 && wrq === 1'b0 && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk(rdat & m, e);
        end
    end
    // Main sequence
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        exp_rd(5'h14, 32'h0, 32'hffffffff);
        arr <= 8'($random(seed));
        ex = $random(seed) & 32'h1ffff;
        bus(1'b1, `FWS_OFF_ADDR, ex);
        op(`FWS_OP_READ);
        chk({15'h0, fl_a}, ex);
        exp_rd(`FWS_OFF_ADDR, ex, 32'h1ffff);
        exp_rd(`FWS_OFF_STAT, {16'h0, arr, 8'h02}, 32'hff07);
        blen <= 8'h05;
        bus(1'b1, `FWS_OFF_WDATA, 32'h55);
        op(`FWS_OP_WRITE);
        op(`FWS_OP_POLL);
        exp_rd(`FWS_OFF_STAT, {16'h0, arr, 8'h02}, 32'hff07);
        fail <= 1'b1;
        op(`FWS_OP_WRITE);
        ex = {24'h0, rsts} + 32'h1;
        op(`FWS_OP_POLL);
        exp_rd(`FWS_OFF_STAT, 32'h1c, 32'h1f);
        chk({24'h0, rsts}, ex);
        fail <= 1'b0;
        win <= 1'b1;
        blen <= 8'h02;
        arr <= 8'h00;
        op(`FWS_OP_GUARD);
        exp_rd(`FWS_OFF_STAT, 32'h40, 32'h60);
        ex = {24'h0, rsts} + 32'h1;
        op(`FWS_OP_RESET);
        chk({24'h0, rsts}, ex);
        chk({23'h0, dq_oe, dq_o}, {24'h0, `FWS_RESET_DATA});
        blen <= 8'h00;
        arr <= 8'h08;
        op(`FWS_OP_GUARD);
        exp_rd(`FWS_OFF_STAT, 32'h20, 32'h60);
        bus(1'b1, `FWS_OFF_CTRL, 32'h1);
        op(`FWS_OP_GUARD);
        exp_rd(`FWS_OFF_STAT, 32'h00, 32'h60);
        // Suspended erase: status bit still, sector bit toggling
        blen <= 8'h03;
        susp <= 1'b1;
        op(`FWS_OP_WRITE);
        op(`FWS_OP_POLL);
        exp_rd(`FWS_OFF_STAT, 32'h12, 32'h1f);
        finish_test;
    end
endmodule
`default_nettype wire
